// ===== inc/cno_pkg.sv
// Constants and carrier types for the CANopen slave node.
// Assumes one 25 MHz clock and a CAN controller moving whole frames.
//
// Overview of operation
// [R1] Four stable node states, init to stopped
// [R2] Power-up enters initializing without any command
// [R3] Initializing ends by moving to pre-operational
// [R4] Reset-application phase, then reset-communication phase
// [R5] Start command: pre-op or stopped to operational
// [R6] Stop to stopped; enter-preop from oper/stopped
// [R7] Reset commands honoured from any stable state
// [R8] Node control on identifier 0, address byte 1
// [R9] Specifiers 01, 02, 80, 81, 82 decoded
// [R10] Commands executed at once, never answered
// [R11] Service data only in pre-op and operational
// [R12] Objects gated by node state per table
// [R13] One boot-up frame on entering pre-operational; code sends it only after reset-communication, not on the enter-preop command
// [R14] Heartbeat only; node guarding not supported
// [R15] Heartbeat sent every configured producer interval
// [R16] Consumer timeout raises heartbeat error event
// [R17] Network holds exactly one master
// [R18] Process data carries 1 to 8 bytes, unacknowledged
// [R19] Type 0: send on SYNC if data changed
// [R20] Type N: send every N SYNC messages
// [R21] Types 254, 255: send on change or event
// [R22] Payload concatenates mapped objects in list order
// [R23] Own or zero address only; unknown specifiers ignored
// [R24] Identifier, type, inhibit, event timer govern sending
// [R25] Emergency on error, code zero once cleared
package cno_pkg;

    // Timebase: a 100 us tick, ten ticks per millisecond
    localparam int CLK_NS = 40;
    localparam int TICK_NS = 100000;
    localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int MS_TICKS = 10;

    // Frame identifiers
    localparam logic [10:0] COB_NMT = 11'h000;
    localparam logic [10:0] COB_SYNC = 11'h080;
    localparam logic [10:0] COB_EMCY_BASE = 11'h080;
    localparam logic [10:0] COB_SDO_RX_BASE = 11'h600;
    localparam logic [10:0] COB_HB_BASE = 11'h700;

    // Node control command specifiers
    localparam logic [7:0] CS_START = 8'h01;
    localparam logic [7:0] CS_STOP = 8'h02;
    localparam logic [7:0] CS_PREOP = 8'h80;
    localparam logic [7:0] CS_RST_APP = 8'h81;
    localparam logic [7:0] CS_RST_COMM = 8'h82;

    // State byte carried by boot-up and heartbeat frames
    localparam logic [7:0] HB_BOOT = 8'h00;
    localparam logic [7:0] HB_STOPPED = 8'h04;
    localparam logic [7:0] HB_OPER = 8'h05;
    localparam logic [7:0] HB_PREOP = 8'h7F;

    // Transmission types
    localparam logic [7:0] TT_SYNC_ACYC = 8'h00;
    localparam logic [7:0] TT_SYNC_MAX = 8'hF0;
    localparam logic [7:0] TT_EVT_MFR = 8'hFE;
    localparam logic [7:0] TT_EVT_DEV = 8'hFF;

    // Emergency error register value while an error stands
    localparam logic [7:0] ERR_REG_GENERIC = 8'h01;

    // Mapping geometry
    localparam int MAP_N = 4;
    localparam int OBJ_W = 32;
    localparam int FRAME_BYTES = 8;

    // Node state, one-hot
    typedef enum logic [4:0] {
        ST_RST_APP = 5'b00001,
        ST_RST_COMM = 5'b00010,
        ST_PREOP = 5'b00100,
        ST_OPER = 5'b01000,
        ST_STOPPED = 5'b10000
    } cno_nmt_t;

    // One CAN data frame
    typedef struct packed {
        logic [10:0] cob_id;
        logic [3:0] dlc;
        logic [63:0] data;
    } cno_frame_t;

    // Node and heartbeat configuration
    typedef struct packed {
        logic [6:0] node_id;
        logic [15:0] hb_prod_ms;
        logic [15:0] hb_cons_ms;
        logic [6:0] hb_cons_node;
    } cno_nmt_cfg_t;

    // Transmit process data communication parameters
    typedef struct packed {
        logic [10:0] cob_id;
        logic [7:0] trans_type;
        logic [15:0] inhibit;
        logic [15:0] event_ms;
    } cno_pdo_comm_t;

    // One mapping entry and the whole mapping list
    typedef struct packed {
        logic [1:0] obj_sel;
        logic [5:0] len_bits;
    } cno_map_ent_t;

    typedef struct packed {
        logic [2:0] count;
        cno_map_ent_t [MAP_N-1:0] ent;
    } cno_pdo_map_t;

endpackage

// ===== verilog/cno_pdo_map.sv
// Process data payload packer: mapped objects concatenated in list order.
// Assumes objects are stable application values on the core clock.
`timescale 1ns/1ns
module cno_pdo_map
(
    // Mapping and object values
    input wire cno_pkg::cno_pdo_map_t map_in,
    input wire logic [cno_pkg::MAP_N-1:0][cno_pkg::OBJ_W-1:0] objects_in,
    // Packed payload
    output logic [63:0] data_out,
    output logic [3:0] dlc_out
);

    // Running bit offset and accumulated payload per entry
    logic [7:0] off [0:cno_pkg::MAP_N];
    logic [63:0] acc [0:cno_pkg::MAP_N];
    logic [7:0] bytes_w;

    assign off[0] = 8'h00;
    assign acc[0] = 64'h0;

    // Each entry lands right after the previous one, low bits first
    genvar i;
    generate
        for (i = 0; i < cno_pkg::MAP_N; i++)
        begin : g_ent
            logic [5:0] len;
            logic [63:0] obj;
            logic [63:0] mask;
            // Entries past the count contribute nothing
            assign len = (3'(i) >= map_in.count) ? 6'h00 :
                (map_in.ent[i].len_bits > 6'(cno_pkg::OBJ_W)) ?
                6'(cno_pkg::OBJ_W) : map_in.ent[i].len_bits;
            assign mask = (64'h1 << len) - 64'h1;
            assign obj = {32'h0, objects_in[map_in.ent[i].obj_sel]} & mask;
            // Bits beyond 64 fall off; software keeps the sum in range
            assign acc[i+1] = acc[i] | (obj << off[i]); // [R22]
            assign off[i+1] = off[i] + {2'b00, len};
        end
    endgenerate

    // Length in bytes, rounded up and held to 1..8
    assign bytes_w = (off[cno_pkg::MAP_N] + 8'h07) >> 3;
    assign dlc_out = (bytes_w == 8'h00) ? 4'h1 :
        (bytes_w > 8'(cno_pkg::FRAME_BYTES)) ? 4'(cno_pkg::FRAME_BYTES) :
        bytes_w[3:0]; // [R18]
    assign data_out = acc[cno_pkg::MAP_N];

endmodule

// ===== verilog/cno_nmt_pdo_slave.sv
// CANopen slave node: states, node control, heartbeat, process data.
// Assumes received frames arrive as one-cycle strobes on the core clock
// and the CAN controller takes frames by valid and ready.
`timescale 1ns/1ns
module cno_nmt_pdo_slave
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Configuration
    input wire cno_pkg::cno_nmt_cfg_t cfg_in,
    input wire cno_pkg::cno_pdo_comm_t tpdo_comm_in,
    input wire cno_pkg::cno_pdo_map_t tpdo_map_in,
    input wire logic [10:0] rpdo_cob_in,
    // Application data and events
    input wire logic [cno_pkg::MAP_N-1:0][cno_pkg::OBJ_W-1:0] objects_in,
    input wire logic event_in,
    input wire logic error_in,
    input wire logic [15:0] error_code_in,
    // Received frames
    input wire logic rx_valid_in,
    input wire cno_pkg::cno_frame_t rx_frame_in,
    // Transmit frames
    output logic tx_valid_out,
    output cno_pkg::cno_frame_t tx_frame_out,
    input wire logic tx_ready_in,
    // Status and gates
    output cno_pkg::cno_nmt_t nmt_state_out,
    output logic sdo_enable_out,
    output logic sync_enable_out,
    output logic pdo_enable_out,
    output logic error_state_out,
    output logic hb_error_out,
    output logic sdo_req_out,
    output logic rpdo_valid_out,
    output logic [63:0] rpdo_data_out
);

    // Whole module state
    typedef struct packed {
        cno_pkg::cno_nmt_t nmt;
        logic boot_pend;
        logic emcy_pend;
        logic hb_pend;
        logic pdo_pend;
        logic [15:0] emcy_code;
        logic err;
        logic err_prev;
        logic [11:0] tick_cnt;
        logic [3:0] ms_cnt;
        logic [15:0] hb_prod_cnt;
        logic [15:0] hb_cons_cnt;
        logic hb_armed;
        logic hb_err;
        logic [7:0] sync_cnt;
        logic [15:0] inhibit_cnt;
        logic [15:0] evt_cnt;
        logic [63:0] last_data;
        logic tx_valid;
        cno_pkg::cno_frame_t tx_frame;
        logic sdo_req;
        logic rpdo_valid;
        logic [63:0] rpdo_data;
    } cno_slv_state_t;

    cno_slv_state_t s_q; // Registered state
    cno_slv_state_t s_d; // Next state

    // Packed payload from the mapping
    logic [63:0] map_data;
    logic [3:0] map_dlc;

    // State class decodes; st_init covers either reset phase
    logic st_init, st_preop, st_oper;

    // Timebase strobes
    logic tick; // Every 100 us
    logic ms; // Every millisecond

    // Received frame decodes
    logic [7:0] rx_cs;
    logic [6:0] rx_addr;
    logic nmt_hit, sync_hit, hb_rx_hit, sdo_hit, rpdo_hit;

    // Transmit process data decodes
    logic [7:0] tt;
    logic tt_sync_n, tt_event, changed, evt_expire;
    logic [7:0] hb_state;

    // Payload packing
    cno_pdo_map u_map
    (
        .map_in(tpdo_map_in),
        .objects_in(objects_in),
        .data_out(map_data),
        .dlc_out(map_dlc)
    );

    // State classes
    assign st_init = (s_q.nmt == cno_pkg::ST_RST_APP) ||
        (s_q.nmt == cno_pkg::ST_RST_COMM);
    assign st_preop = (s_q.nmt == cno_pkg::ST_PREOP);
    assign st_oper = (s_q.nmt == cno_pkg::ST_OPER);

    // Free-running timebase
    assign tick = (s_q.tick_cnt == 12'(cno_pkg::TICK_CYC - 1));
    assign ms = tick && (s_q.ms_cnt == 4'(cno_pkg::MS_TICKS - 1));

    // Node control frame: specifier in byte 0, address in byte 1
    assign rx_cs = rx_frame_in.data[7:0];
    assign rx_addr = rx_frame_in.data[14:8];
    assign nmt_hit = rx_valid_in && (rx_frame_in.cob_id == cno_pkg::COB_NMT)
        && (rx_frame_in.dlc >= 4'h2) && !rx_frame_in.data[15]
        && ((rx_addr == cfg_in.node_id) || (rx_addr == 7'h00))
        && !st_init; // [R8] [R23] [R12]

    // SYNC counts only in pre-operational and operational
    assign sync_hit = rx_valid_in && (rx_frame_in.cob_id == cno_pkg::COB_SYNC)
        && (st_preop || st_oper); // [R12]

    // Heartbeat from the monitored producer
    assign hb_rx_hit = rx_valid_in && (rx_frame_in.dlc != 4'h0)
        && (rx_frame_in.cob_id ==
        (cno_pkg::COB_HB_BASE + {4'h0, cfg_in.hb_cons_node}));

    // Service data request, refused outside pre-op and operational
    assign sdo_hit = rx_valid_in && (st_preop || st_oper)
        && (rx_frame_in.cob_id ==
        (cno_pkg::COB_SDO_RX_BASE + {4'h0, cfg_in.node_id})); // [R11]

    // Received process data, used only while operational
    assign rpdo_hit = rx_valid_in && st_oper
        && (rx_frame_in.cob_id == rpdo_cob_in)
        && (rx_frame_in.dlc != 4'h0)
        && (rx_frame_in.dlc <= 4'(cno_pkg::FRAME_BYTES)); // [R12] [R18]

    // Transmission type classes
    assign tt = tpdo_comm_in.trans_type;
    assign tt_sync_n = (tt != cno_pkg::TT_SYNC_ACYC)
        && (tt <= cno_pkg::TT_SYNC_MAX);
    assign tt_event = (tt == cno_pkg::TT_EVT_MFR)
        || (tt == cno_pkg::TT_EVT_DEV); // [R21]
    assign changed = (map_data != s_q.last_data);
    assign evt_expire = ms && (tpdo_comm_in.event_ms != 16'h0000)
        && (s_q.evt_cnt + 16'h0001 >= tpdo_comm_in.event_ms); // [R24]

    // State byte for heartbeat frames
    always_comb
    begin
        unique case (s_q.nmt)
            cno_pkg::ST_OPER: hb_state = cno_pkg::HB_OPER;
            cno_pkg::ST_STOPPED: hb_state = cno_pkg::HB_STOPPED;
            cno_pkg::ST_PREOP: hb_state = cno_pkg::HB_PREOP;
            default: hb_state = cno_pkg::HB_BOOT;
        endcase
    end

    // Next state of the whole node
    always_comb
    begin
        s_d = s_q;
        s_d.hb_err = 1'b0;
        s_d.sdo_req = sdo_hit;
        s_d.rpdo_valid = rpdo_hit;
        if (rpdo_hit)
            s_d.rpdo_data = rx_frame_in.data;
        // Timebase counters
        s_d.tick_cnt = tick ? 12'h000 : s_q.tick_cnt + 12'h001;
        if (tick)
            s_d.ms_cnt = ms ? 4'h0 : s_q.ms_cnt + 4'h1;
        // Node state machine
        unique case (s_q.nmt)
            cno_pkg::ST_RST_APP:
            begin
                // Application phase done, go on to communication
                s_d.nmt = cno_pkg::ST_RST_COMM; // [R4]
                s_d.err = 1'b0;
            end
            cno_pkg::ST_RST_COMM:
            begin
                // Communication phase done, enter pre-operational
                s_d.nmt = cno_pkg::ST_PREOP; // [R3] [R4]
                s_d.boot_pend = 1'b1; // [R13]
            end
            cno_pkg::ST_PREOP, cno_pkg::ST_OPER, cno_pkg::ST_STOPPED:
                // Commands act at once; nothing is sent back
                if (nmt_hit) // [R10]
                    unique case (rx_cs)
                        cno_pkg::CS_START:
                            s_d.nmt = cno_pkg::ST_OPER; // [R5]
                        cno_pkg::CS_STOP:
                            s_d.nmt = cno_pkg::ST_STOPPED; // [R6]
                        cno_pkg::CS_PREOP:
                            s_d.nmt = cno_pkg::ST_PREOP; // [R6]
                        cno_pkg::CS_RST_APP:
                            s_d.nmt = cno_pkg::ST_RST_APP; // [R7] [R9]
                        cno_pkg::CS_RST_COMM:
                            s_d.nmt = cno_pkg::ST_RST_COMM; // [R7] [R9]
                        default:
                            s_d.nmt = s_q.nmt; // [R23]
                    endcase
            default:
                // Corrupted code: restart the node cleanly
                s_d.nmt = cno_pkg::ST_RST_APP; // [R1]
        endcase
        // Transmit slot: taken by the controller, then refilled
        if (s_q.tx_valid && tx_ready_in)
            s_d.tx_valid = 1'b0;
        else if (!s_q.tx_valid)
        begin
            // Boot-up first, then emergency, heartbeat, process data
            if (s_q.boot_pend)
            begin
                s_d.tx_valid = 1'b1;
                s_d.boot_pend = 1'b0;
                s_d.tx_frame = '{cno_pkg::COB_HB_BASE +
                    {4'h0, cfg_in.node_id}, 4'h1, 64'h0}; // [R13]
            end
            else if (s_q.emcy_pend)
            begin
                s_d.tx_valid = 1'b1;
                s_d.emcy_pend = 1'b0;
                s_d.tx_frame = '{cno_pkg::COB_EMCY_BASE +
                    {4'h0, cfg_in.node_id}, 4'h8, {40'h0,
                    (s_q.err ? cno_pkg::ERR_REG_GENERIC : 8'h00),
                    s_q.emcy_code}}; // [R25]
            end
            else if (s_q.hb_pend)
            begin
                s_d.tx_valid = 1'b1;
                s_d.hb_pend = 1'b0;
                s_d.tx_frame = '{cno_pkg::COB_HB_BASE +
                    {4'h0, cfg_in.node_id}, 4'h1,
                    {56'h0, hb_state}}; // [R15]
            end
            else if (s_q.pdo_pend)
            begin
                // Snapshot the payload so later changes are seen
                s_d.tx_valid = 1'b1;
                s_d.pdo_pend = 1'b0;
                s_d.tx_frame = '{tpdo_comm_in.cob_id, map_dlc,
                    map_data}; // [R22] [R24]
                s_d.last_data = map_data;
                s_d.inhibit_cnt = tpdo_comm_in.inhibit; // [R24]
                s_d.evt_cnt = 16'h0000;
            end
        end
        // Heartbeat producer, counted in milliseconds
        if (st_init || (cfg_in.hb_prod_ms == 16'h0000))
            s_d.hb_prod_cnt = 16'h0000;
        else if (ms)
            if (s_q.hb_prod_cnt + 16'h0001 >= cfg_in.hb_prod_ms)
            begin
                s_d.hb_prod_cnt = 16'h0000;
                s_d.hb_pend = 1'b1; // [R14] [R15]
            end
            else
                s_d.hb_prod_cnt = s_q.hb_prod_cnt + 16'h0001;
        // Heartbeat consumer, armed by the first heartbeat seen
        if (st_init || (cfg_in.hb_cons_ms == 16'h0000))
        begin
            s_d.hb_armed = 1'b0;
            s_d.hb_cons_cnt = 16'h0000;
        end
        else if (hb_rx_hit)
        begin
            s_d.hb_armed = 1'b1;
            s_d.hb_cons_cnt = 16'h0000;
        end
        else if (s_q.hb_armed && ms)
            if (s_q.hb_cons_cnt + 16'h0001 >= cfg_in.hb_cons_ms)
            begin
                // One event per silence; next heartbeat re-arms
                s_d.hb_err = 1'b1; // [R16]
                s_d.hb_armed = 1'b0;
            end
            else
                s_d.hb_cons_cnt = s_q.hb_cons_cnt + 16'h0001;
        // Emergency on both edges of error_in, queued only in pre-op or operational
        s_d.err_prev = error_in;
        if (!st_init && error_in && !s_q.err_prev)
        begin
            s_d.err = 1'b1;
            s_d.emcy_code = error_code_in;
            s_d.emcy_pend = st_preop || st_oper || s_q.emcy_pend; // [R25]
        end
        else if (!st_init && !error_in && s_q.err_prev)
        begin
            s_d.err = 1'b0;
            s_d.emcy_code = 16'h0000;
            s_d.emcy_pend = st_preop || st_oper || s_q.emcy_pend; // [R25]
        end
        // Inhibit time in 100 us units
        if (tick && (s_q.inhibit_cnt != 16'h0000))
            s_d.inhibit_cnt = s_q.inhibit_cnt - 16'h0001; // [R24]
        // Event timer in milliseconds, restarted when it expires
        if (!tt_event || evt_expire || (tpdo_comm_in.event_ms == 16'h0000))
            s_d.evt_cnt = 16'h0000;
        else if (ms)
            s_d.evt_cnt = s_q.evt_cnt + 16'h0001;
        // Transmit process data triggers, operational only
        if (!st_oper)
        begin
            s_d.pdo_pend = 1'b0; // [R12]
            s_d.sync_cnt = 8'h00;
        end
        else if ((tt == cno_pkg::TT_SYNC_ACYC) && sync_hit && changed)
            s_d.pdo_pend = 1'b1; // [R19]
        else if (tt_sync_n && sync_hit)
        begin
            if (s_q.sync_cnt + 8'h01 >= tt)
            begin
                s_d.sync_cnt = 8'h00;
                s_d.pdo_pend = 1'b1; // [R20]
            end
            else
                s_d.sync_cnt = s_q.sync_cnt + 8'h01;
        end
        // Inhibit holds back a data-change send; an event_in pulse or timer expiry during it is dropped
        else if (tt_event && (changed || event_in || evt_expire)
            && (s_q.inhibit_cnt == 16'h0000))
            s_d.pdo_pend = 1'b1; // [R21] [R24]
        // Either reset phase clears the communication side
        if (st_init)
        begin
            s_d.emcy_pend = 1'b0;
            s_d.hb_pend = 1'b0;
            s_d.pdo_pend = 1'b0;
            s_d.tx_valid = 1'b0;
            s_d.inhibit_cnt = 16'h0000;
            s_d.evt_cnt = 16'h0000;
            s_d.last_data = 64'h0;
        end
    end

    // State register; reset starts the initializing sequence
    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
            s_q <= '{nmt: cno_pkg::ST_RST_APP, default: '0}; // [R2]
        else
            s_q <= s_d;
    end

    // Outputs, all from the state register
    assign tx_valid_out = s_q.tx_valid;
    assign tx_frame_out = s_q.tx_frame;
    assign nmt_state_out = s_q.nmt;
    assign sdo_enable_out = st_preop || st_oper; // [R11]
    assign sync_enable_out = st_preop || st_oper; // [R12]
    assign pdo_enable_out = st_oper; // [R12]
    assign error_state_out = s_q.err;
    assign hb_error_out = s_q.hb_err;
    assign sdo_req_out = s_q.sdo_req;
    assign rpdo_valid_out = s_q.rpdo_valid;
    assign rpdo_data_out = s_q.rpdo_data;

endmodule

// ===== dv/cno_checker.sv
// Checker for the slave node: state moves, boot frame, gates.
// Bound to the slave; sees only its ports.
`timescale 1ns/1ns
module cno_checker
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Watched ports
    input wire cno_pkg::cno_nmt_cfg_t cfg_in,
    input wire logic rx_valid_in,
    input wire cno_pkg::cno_frame_t rx_frame_in,
    input wire logic tx_valid_out,
    input wire cno_pkg::cno_frame_t tx_frame_out,
    input wire cno_pkg::cno_nmt_t nmt_state_out,
    input wire logic sdo_enable_out,
    input wire logic pdo_enable_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic hit; // Node control frame for this node
    logic up; // Stable state that takes commands
    logic [7:0] cs; // Command specifier byte
    assign cs = rx_frame_in.data[7:0];
    assign up = nmt_state_out inside {cno_pkg::ST_PREOP,
        cno_pkg::ST_OPER, cno_pkg::ST_STOPPED};
    assign hit = rx_valid_in && rx_frame_in.cob_id == 11'h000
        && rx_frame_in.dlc >= 4'h2 && (rx_frame_in.data[15:8] == 8'h00
        || rx_frame_in.data[15:8] == {1'b0, cfg_in.node_id});
    // Reset phases run one after the other, a cycle each
    sequence s_comm;
        nmt_state_out == cno_pkg::ST_RST_COMM
        ##1 nmt_state_out == cno_pkg::ST_PREOP;
    endsequence
    sequence s_phases;
        nmt_state_out == cno_pkg::ST_RST_APP ##1 s_comm;
    endsequence
    chk_boot_order: assert property ($rose(reset_n_in) |-> s_phases)
        else $error("boot phases out of order");
    chk_boot_frame: assert property ($rose(reset_n_in) |-> ##3
        tx_valid_out && tx_frame_out.dlc == 4'h1
        && tx_frame_out.data[7:0] == 8'h00 && tx_frame_out.cob_id ==
        cno_pkg::COB_HB_BASE + cfg_in.node_id)
        else $error("boot frame missing or wrong");
    chk_cmd_start: assert property (hit && up && cs == 8'h01 |=>
        nmt_state_out == cno_pkg::ST_OPER) else $error("start ignored");
    chk_cmd_stop: assert property (hit && up && cs == 8'h02 |=>
        nmt_state_out == cno_pkg::ST_STOPPED) else $error("stop ignored");
    chk_cmd_preop: assert property (hit && up && cs == 8'h80 |=>
        nmt_state_out == cno_pkg::ST_PREOP) else $error("preop ignored");
    chk_cmd_rstapp: assert property (hit && up && cs == 8'h81
        |=> s_phases) else $error("application reset wrong");
    chk_cmd_rstcomm: assert property (hit && up && cs == 8'h82
        |=> s_comm) else $error("communication reset wrong");
    chk_ignore_cmd: assert property (rx_valid_in && up && !(hit
        && cs inside {8'h01, 8'h02, 8'h80, 8'h81, 8'h82})
        |=> $stable(nmt_state_out)) else $error("state moved");
    chk_gate_objects: assert property (pdo_enable_out ==
        (nmt_state_out == cno_pkg::ST_OPER) && sdo_enable_out ==
        (nmt_state_out inside {cno_pkg::ST_PREOP, cno_pkg::ST_OPER}))
        else $error("object gates wrong");
endmodule

// ===== dv/cno_master_model.sv
// Model of the single master and CAN controller around the slave.
// Sends frames to it, takes and counts its frames.
`timescale 1ns/1ns
module cno_master_model
(
    // Clock and mode
    input wire logic clk_in,
    input wire logic slow_in,
    // Frames from the slave
    input wire logic tx_valid_in,
    input wire cno_pkg::cno_frame_t tx_frame_in,
    output logic tx_ready_out,
    // Frames to the slave
    output logic rx_valid_out,
    output cno_pkg::cno_frame_t rx_frame_out
);
    int n_frames = 0; // Frames taken from the slave
    cno_pkg::cno_frame_t last_q; // Last frame taken
    initial
    begin
        tx_ready_out = 1'b1;
        rx_valid_out = 1'b0;
        rx_frame_out = '0;
    end
    // Take frames; a slow controller is ready every other cycle
    always @(posedge clk_in)
    begin
        if (tx_valid_in && tx_ready_out)
        begin
            n_frames <= n_frames + 1;
            last_q <= tx_frame_in;
        end
        tx_ready_out <= slow_in ? !tx_ready_out : 1'b1;
    end
    // One frame per call; idle bus shows the inverse, not the old frame
    task automatic send(input logic [10:0] id, input logic [3:0] dlc,
        input logic [63:0] data);
        @(posedge clk_in);
        rx_valid_out <= 1'b1;
        rx_frame_out <= '{id, dlc, data};
        @(posedge clk_in);
        rx_valid_out <= 1'b0;
        rx_frame_out <= ~rx_frame_out;
    endtask
endmodule

// ===== dv/test_cno_nmt_pdo_slave.sv
// Self-checking bench for the slave node, node address 05.
// Frames go through the master model; checker bound below.
`timescale 1ns/1ns
module test_cno_nmt_pdo_slave;
    logic clk, rst_n, slow, evt, err, rx_valid, tx_valid, tx_ready;
    logic sdo_en, sync_en, pdo_en, sdo_req;
    cno_pkg::cno_nmt_cfg_t cfg;
    cno_pkg::cno_pdo_comm_t comm;
    cno_pkg::cno_pdo_map_t map;
    cno_pkg::cno_frame_t rx_frame, tx_frame;
    cno_pkg::cno_nmt_t state;
    logic [3:0][31:0] objs;
    int n_errors = 0;
    int n_tests = 0;
    int n_sdo = 0;
    int base;
    int nf; // Frames taken by the model
    cno_pkg::cno_frame_t lq; // Last frame taken by the model
    assign nf = u_cno_master_model.n_frames;
    assign lq = u_cno_master_model.last_q;
    // Rows: specifier, address, expected state
    logic [23:0] rows [10] = '{24'h010508, 24'h020010, 24'h800504,
        24'h020510, 24'h010008, 24'h800004, 24'h030504, 24'h010604,
        24'h810504, 24'h820004};
    cno_nmt_pdo_slave u_cno_nmt_pdo_slave
    (
        .core_clk_in(clk), .reset_n_in(rst_n), .cfg_in(cfg),
        .tpdo_comm_in(comm), .tpdo_map_in(map), .rpdo_cob_in(11'h205),
        .objects_in(objs), .event_in(evt), .error_in(err),
        .error_code_in(16'h5A01), .rx_valid_in(rx_valid),
        .rx_frame_in(rx_frame), .tx_valid_out(tx_valid),
        .tx_frame_out(tx_frame), .tx_ready_in(tx_ready),
        .nmt_state_out(state), .sdo_enable_out(sdo_en),
        .sync_enable_out(sync_en), .pdo_enable_out(pdo_en),
        .error_state_out(), .hb_error_out(), .sdo_req_out(sdo_req),
        .rpdo_valid_out(), .rpdo_data_out()
    );
    cno_master_model u_cno_master_model
    (
        .clk_in(clk), .slow_in(slow), .tx_valid_in(tx_valid),
        .tx_frame_in(tx_frame), .tx_ready_out(tx_ready),
        .rx_valid_out(rx_valid), .rx_frame_out(rx_frame)
    );
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Short hand for a frame then a settle wait
    task automatic go(input logic [10:0] id, input logic [63:0] d);
        u_cno_master_model.send(id, (id == 11'h080) ? 4'h0 : 4'h8, d);
        repeat (8) @(posedge clk);
        #1;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Count service data requests seen
    always @(posedge clk)
        if (sdo_req === 1'b1)
            n_sdo++;
    initial
    begin
        rst_n = 1'b0;
        slow = 1'b0;
        evt = 1'b0;
        err = 1'b0;
        cfg = '{7'h05, 16'h0000, 16'h0000, 7'h00};
        comm = '{11'h185, 8'hF1, 16'h0000, 16'h0000};
        map = {3'd2, 8'h00, 8'h00, 8'h10, 8'h48};
        objs = {32'h0, 32'h0, 32'h5A5A5A77, 32'h1234ABCD};
        repeat (7) @(posedge clk);
        #1;
        check(state, cno_pkg::ST_RST_APP);
        check(tx_valid, 1'b0);
        @(posedge clk) rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        check(nf, 1);
        check({lq.cob_id, lq.data[7:0]}, {11'h705, 8'h00});
        $display("reset test done");
        base = nf;
        foreach (rows[i])
        begin
            go(11'h000, {48'h0, rows[i][15:8], rows[i][23:16]});
            check(state, rows[i][4:0]);
            check({sdo_en, sync_en, pdo_en},
                {{2{rows[i][3:2] != 2'b00}}, rows[i][3]});
        end
        check(nf - base, 2);
        $display("command rows done");
        go(11'h000, 64'h0501);
        go(11'h605, 64'h40); // Accepted in operational
        @(posedge clk) comm.trans_type <= 8'h03;
        slow <= 1'b1;
        base = nf;
        repeat (6) go(cno_pkg::COB_SYNC, 64'h0);
        check(nf - base, 2);
        check({lq.cob_id, lq.dlc, lq.data[23:0]},
            {11'h185, 4'h3, 24'hABCD77});
        @(posedge clk) comm.trans_type <= 8'h00;
        go(cno_pkg::COB_SYNC, 64'h0); // Unchanged data, nothing sent
        @(posedge clk) objs[0] <= 32'h12341111;
        go(cno_pkg::COB_SYNC, 64'h0);
        check(nf - base, 3);
        check(lq.data[23:0], 24'h111177);
        @(posedge clk) comm.trans_type <= 8'hFF;
        @(posedge clk) evt <= 1'b1;
        @(posedge clk) evt <= 1'b0;
        @(posedge clk) err <= 1'b1; // Error rises while operational
        go(11'h000, 64'h0502); // Stop; later service data refused
        check(nf - base, 5);
        check({lq.cob_id, lq.dlc, lq.data[23:0]},
            {11'h085, 4'h8, 24'h015A01});
        $display("process data tests done");
        go(11'h605, 64'h40);
        check(n_sdo, 1);
        $display("service data test done");
        complete_run();
    end
    // Watchdog well past the expected few hundred cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        complete_run();
    end
endmodule
bind cno_nmt_pdo_slave cno_checker u_cno_checker (.*);
